// file: verilog/wdc_pkg.sv
/*
 * shared constants and carrier types for the watchdog downcounter block.
 * assumes one 250 mhz clock and a single ahb-lite master on the bus.
 */
package wdc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] WDC_CNT_CTRL_OFS   = 8'hd8;
    localparam logic [7:0] WDC_OPT_OFS        = 8'hdc;
    localparam logic [7:0] WDC_STAT_OFS       = 8'he0;
    localparam logic [7:0] WDC_CNT_CTRL_RST   = 8'hfe;
    localparam int         WDC_ACT_BIT        = 0;
    localparam int         WDC_SOFT_RESET_BIT = 1;
    localparam int         WDC_OPT_HW_BIT     = 0;
    localparam int         WDC_OPT_STOP_BIT   = 1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         WDC_CLK_DIV        = 12;
    localparam logic [3:0] WDC_DIV_LAST       = 4'(WDC_CLK_DIV - 1);
    // second stage: 12 x 256 gives the 3072-cycle step of one count
    localparam int         WDC_PRE_DIV        = 256;
    localparam logic [7:0] WDC_PRE_LAST       = 8'(WDC_PRE_DIV - 1);
    localparam int         WDC_CNT_W          = 7;
    localparam int         WDC_STAB_CYC       = 2048;
    localparam logic [11:0] WDC_STAB_LAST     = 12'(WDC_STAB_CYC - 1);

    // ------------------------------------------------------------------
    // ahb-lite codes
    // ------------------------------------------------------------------
    localparam logic [1:0] WDC_HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0] WDC_HTRANS_SEQ     = 2'h3;

    typedef struct packed {
        logic        sel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic        hready;
    } wdc_ahb_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic       write;
    } wdc_acc_t;

    typedef enum logic [2:0] {
        WDC_RUN   = 3'b001,
        WDC_HOLD  = 3'b010,
        WDC_RESET = 3'b100
    } wdc_state_t;

endpackage

// file: verilog/wdc_sync.sv
/*
 * three-stage synchroniser with agreement filter for a pin input.
 * assumes the pin is asynchronous to the clock.
 */
`timescale 1ns/1ns
module wdc_sync (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    input  wire logic i_rst_val,
    output logic      o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic lvl_reg;

    // first stage feeds the second and nothing else
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lvl_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
        end
    end

    assign o_level = lvl_reg;
endmodule

// file: verilog/wdc_ahb_slave.sv
/*
 * ahb-lite slave front end: captures the address phase, zero wait states.
 * assumes single word transfers; response is always okay.
 */
`timescale 1ns/1ns
module wdc_ahb_slave
    import wdc_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire wdc_ahb_req_t i_req,
    output wdc_acc_t          o_acc,
    output logic              o_hreadyout,
    output logic              o_hresp
);
    wdc_acc_t acc_reg;
    logic     take;

    assign take = i_req.sel && i_req.hready &&
                  (i_req.htrans == WDC_HTRANS_NONSEQ ||
                   i_req.htrans == WDC_HTRANS_SEQ);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_reg <= '0;
        end else if (i_req.hready) begin
            acc_reg.valid <= take;
            acc_reg.addr  <= i_req.haddr[7:0];
            acc_reg.write <= i_req.hwrite;
        end
    end

    assign o_acc       = acc_reg;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
endmodule

// file: verilog/wdc_top.sv
/*
 * watchdog downcounter: 7-bit reloadable counter behind ahb-lite.
 * assumes the option and stop-request pins are asynchronous straps/levels,
 * and that o_MCU_RST_N drives the chip reset and is fed back to I_RST_N
 * through the system's own reset tree.
 */
`timescale 1ns/1ns
module wdc_top
    import wdc_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    input  wire logic        I_HW_OPTION,
    input  wire logic        I_STOP_REQ,
    output logic [31:0]      O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic             O_MCU_RST_N,
    output logic             O_OSC_STOP,
    output logic             O_ACTIVE
);
    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    wdc_ahb_req_t ahb_req;
    wdc_acc_t     acc;
    logic         hw_opt;
    logic         stop_lvl;

    assign ahb_req.sel    = I_HSEL;
    assign ahb_req.haddr  = I_HADDR;
    assign ahb_req.htrans = I_HTRANS;
    assign ahb_req.hwrite = I_HWRITE;
    assign ahb_req.hready = I_HREADY;

    wdc_ahb_slave u_slave (
        .i_clk       (I_REF_CLK),
        .i_rst_n     (I_RST_N),
        .i_req       (ahb_req),
        .o_acc       (acc),
        .o_hreadyout (O_HREADYOUT),
        .o_hresp     (O_HRESP)
    );

    wdc_sync u_sync_hw (
        .i_clk     (I_REF_CLK),
        .i_rst_n   (I_RST_N),
        .i_async   (I_HW_OPTION),
        .i_rst_val (1'b0),
        .o_level   (hw_opt)
    );

    wdc_sync u_sync_stop (
        .i_clk     (I_REF_CLK),
        .i_rst_n   (I_RST_N),
        .i_async   (I_STOP_REQ),
        .i_rst_val (1'b0),
        .o_level   (stop_lvl)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [3:0]           div_reg;
    logic [WDC_CNT_W-1:0] cnt_reg;
    logic                 act_reg;
    logic [11:0]          stab_reg;
    logic                 osc_stop_reg;
    logic [7:0]           rdata_reg;
    wdc_state_t           state_reg;
    wdc_state_t           state_next;

    logic       tick;
    logic       div_wrap;
    logic [7:0] pre_reg;
    logic [6:0] cnt_rev;
    logic       wr_ctrl;
    logic       active;
    logic       timeout;
    logic       soft_rst;
    logic [7:0] wbyte;
    logic [7:0] ctrl_view;

    assign wbyte   = I_HWDATA[7:0];
    assign wr_ctrl = acc.valid && acc.write &&
                     (acc.addr == WDC_CNT_CTRL_OFS) && (state_reg == WDC_RUN);

    assign active = act_reg || hw_opt;

    assign div_wrap = (div_reg == WDC_DIV_LAST) && !osc_stop_reg;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            div_reg <= '0;
        end else if (osc_stop_reg) begin
            div_reg <= div_reg;
        end else if (div_wrap) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    // prescale so one count is 3072 cycles
    assign tick = div_wrap && (pre_reg == WDC_PRE_LAST);

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pre_reg <= '0;
        end else if (div_wrap) begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    // end of count when bit 6 falls
    assign timeout = active && tick && (state_reg == WDC_RUN) &&
                     cnt_reg[WDC_CNT_W-1] && !cnt_reg[WDC_CNT_W-2] &&
                     (cnt_reg[WDC_CNT_W-3:0] == '0);

    assign soft_rst = wr_ctrl && !wbyte[WDC_SOFT_RESET_BIT];

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // reset loads 0xfe view
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_reg <= '1;
        end else if (state_reg != WDC_RUN) begin
            cnt_reg <= '1;
        end else if (wr_ctrl) begin
            cnt_reg <= {<<{wbyte[7:1]}};
        end else if (tick) begin
            cnt_reg <= cnt_reg - 7'h01;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            act_reg <= 1'b0;
        end else if (state_reg != WDC_RUN) begin
            act_reg <= 1'b0;
        end else if (wr_ctrl && wbyte[WDC_ACT_BIT]) begin
            act_reg <= 1'b1;
        end
    end

    // stop acts as wait under hw
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            osc_stop_reg <= 1'b0;
        end else begin
            osc_stop_reg <= stop_lvl && !active && (state_reg == WDC_RUN);
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WDC_RUN: begin
                if (timeout || soft_rst) begin
                    state_next = WDC_RESET;
                end
            end
            WDC_RESET: begin
                state_next = WDC_HOLD;
            end
            WDC_HOLD: begin
                if (stab_reg == WDC_STAB_LAST) begin
                    state_next = WDC_RUN;
                end
            end
            default: begin
                state_next = WDC_RUN;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= WDC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stab_reg <= '0;
        end else if (state_reg == WDC_HOLD) begin
            stab_reg <= stab_reg + 12'h001;
        end else begin
            stab_reg <= '0;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // counter lsb shows in bit 7
    always_comb begin
        for (int i = 0; i < WDC_CNT_W; i++) begin
            cnt_rev[i] = cnt_reg[WDC_CNT_W-1-i];
        end
    end

    assign ctrl_view = {cnt_rev, active};

    // the write lands one cycle late, so a read right after still sees the old value
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_reg <= '0;
        end else if (I_HSEL && I_HREADY && !I_HWRITE && I_HTRANS[1]) begin
            case (I_HADDR[7:0])
                WDC_CNT_CTRL_OFS: rdata_reg <= ctrl_view;
                WDC_OPT_OFS: rdata_reg <= {6'h00, stop_lvl, hw_opt};
                WDC_STAT_OFS: rdata_reg <= {7'h00, osc_stop_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign O_HRDATA    = {24'h000000, rdata_reg};
    assign O_MCU_RST_N = (state_reg == WDC_RUN);
    assign O_OSC_STOP  = osc_stop_reg;
    assign O_ACTIVE    = active;
endmodule

// file: test/wdc_chk.sv
/*
 * concurrent checks on the ports of the watchdog downcounter top.
 * assumes it is bound to wdc_top: one clock, asynchronous low reset.
 */
`timescale 1ns/1ns
module wdc_chk
    import wdc_pkg::*;
(
    input wire logic        I_REF_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic        I_HREADY,
    input wire logic        I_HW_OPTION,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    input wire logic        O_MCU_RST_N,
    input wire logic        O_OSC_STOP,
    input wire logic        O_ACTIVE
);
    logic [11:0] low_n;
    logic        wr_ph;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // length so far of the current internal reset pulse
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            low_n <= 12'h000;
        end else begin
            low_n <= O_MCU_RST_N ? 12'h000 : low_n + 12'h001;
        end
    end

    // data phase of a count register write; writes in reset are dropped
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            wr_ph <= 1'b0;
        end else begin
            wr_ph <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE
                     && I_HADDR[7:0] == WDC_CNT_CTRL_OFS && O_MCU_RST_N;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    bus_okay_a: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus answer not ready or not okay");
    act_sticky_a: assert property (
        O_ACTIVE && O_MCU_RST_N |=> O_ACTIVE || !O_MCU_RST_N)
        else $error("watchdog left active state without reset");
    hw_forced_a: assert property (I_HW_OPTION [*6] |-> O_ACTIVE)
        else $error("hardware option did not force activation");
    hw_no_stop_a: assert property (
        I_HW_OPTION [*6] |-> !O_OSC_STOP)
        else $error("oscillator halted under hardware option");
    stop_idle_a: assert property (O_OSC_STOP |-> !O_ACTIVE)
        else $error("oscillator halted while watchdog active");
    soft_trip_a: assert property (
        wr_ph && !I_HWDATA[1] |-> ##[0:3] !O_MCU_RST_N)
        else $error("soft reset write did not reset");
    hold_len_a: assert property (
        $rose(O_MCU_RST_N) |-> low_n inside {[12'd2048:12'd2050]})
        else $error("internal reset pulse has wrong length");
    rst_clear_a: assert property (
        $rose(O_MCU_RST_N) && !I_HW_OPTION |-> !O_ACTIVE)
        else $error("activation survived internal reset");
endmodule

// file: test/watchdog_downcounter_test.sv
/*
 * self-checking bench for the watchdog downcounter over ahb-lite.
 * assumes zero wait states and a free running count while inactive.
 */
`timescale 1ns/1ns
module watchdog_downcounter_test
    import wdc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n, hsel, hwrite, hw_opt, stop_req, rd_ph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hready_o, hresp, mcu_rst_n, osc_stop, active;
    logic [31:0] exp_q[$];
    logic [7:0]  v;
    int          n_fail, compares, n;

    always #2 clk = ~clk;

    wdc_top uut (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
        .I_HWDATA(hwdata), .I_HREADY(hready_o), .I_HW_OPTION(hw_opt),
        .I_STOP_REQ(stop_req), .O_HRDATA(hrdata), .O_HREADYOUT(hready_o),
        .O_HRESP(hresp), .O_MCU_RST_N(mcu_rst_n), .O_OSC_STOP(osc_stop),
        .O_ACTIVE(active));

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= WDC_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready_o !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge clk); while (hready_o !== 1'b1);
        rd_ph <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // poll the reset output; n ends as the cycles it took
    task wt(input logic lv, input int mx);
        #1;
        n = 0;
        while (mcu_rst_n !== lv && n < mx) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task cy(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task results;
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // read data are taken at the data phase edge, oldest note first
    always @(posedge clk) begin
        if (rd_ph) begin
            chk(hrdata, exp_q.pop_front());
        end
    end

    initial begin
        #150000;
        n_fail++;
        results();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {rst_n, hsel, hwrite, hw_opt, stop_req, rd_ph} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        void'($urandom(56365));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(WDC_CNT_CTRL_OFS, 32'hfe);
        rd(8'h40, 32'h0);
        chk({31'h0, active}, 32'h0);
        // inactive count runs through the trip point unharmed
        bus(1'b1, WDC_CNT_CTRL_OFS, 32'h02);
        cy(3100);
        chk({31'h0, mcu_rst_n}, 32'h1);
        // stop while inactive freezes a random reload
        stop_req <= 1'b1;
        cy(8);
        chk({31'h0, osc_stop}, 32'h1);
        rd(WDC_STAT_OFS, 32'h1);
        v = {8'($urandom) & 8'hfc} | 8'h02;
        bus(1'b1, WDC_CNT_CTRL_OFS, {24'h0, v});
        cy(3100);
        rd(WDC_CNT_CTRL_OFS, {24'h0, v});
        stop_req <= 1'b0;
        cy(8);
        chk({31'h0, osc_stop}, 32'h0);
        // activation sticks, then count 0x41 trips after two ticks
        bus(1'b1, WDC_CNT_CTRL_OFS, 32'hfb);
        cy(2);
        chk({31'h0, active}, 32'h1);
        bus(1'b1, WDC_CNT_CTRL_OFS, 32'hfe);
        cy(2);
        chk({31'h0, active}, 32'h1);
        bus(1'b1, WDC_CNT_CTRL_OFS, 32'h83);
        wt(1'b0, 6400);
        chk(32'(n >= 3072 && n <= 6150), 32'h1);
        wt(1'b1, 2200);
        chk(32'(n > 2040), 32'h1);
        chk({31'h0, active}, 32'h0);
        // clearing the soft reset bit resets at once
        bus(1'b1, WDC_CNT_CTRL_OFS, 32'hfc);
        wt(1'b0, 6);
        chk({31'h0, mcu_rst_n}, 32'h0);
        wt(1'b1, 2200);
        // hardware option forces activation and refuses stop
        @(posedge clk);
        hw_opt <= 1'b1;
        cy(8);
        chk({31'h0, active}, 32'h1);
        @(posedge clk);
        stop_req <= 1'b1;
        cy(8);
        chk({31'h0, osc_stop}, 32'h0);
        rd(WDC_OPT_OFS, 32'h3);
        @(posedge clk);
        {rst_n, hw_opt, stop_req} <= 3'b000;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(WDC_CNT_CTRL_OFS, 32'hfe);
        results();
    end
endmodule

bind wdc_top wdc_chk u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL),
    .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .I_HW_OPTION(I_HW_OPTION),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
    .O_MCU_RST_N(O_MCU_RST_N), .O_OSC_STOP(O_OSC_STOP),
    .O_ACTIVE(O_ACTIVE));
